//--- src/dlrc_pkg.sv
// Package for the delay loop run-time configuration register set.
// Assumes a single 100 MHz fabric clock and a byte-wide parallel configuration bus.
package dlrc_pkg;

  // ----------------------------------------------------------------------
  // Register indices relative to the target base address.
  // ----------------------------------------------------------------------
  localparam logic [1:0] DLRC_IDX_PHASE_A   = 2'h0;
  localparam logic [1:0] DLRC_IDX_PHASE_B   = 2'h1;
  localparam logic [1:0] DLRC_IDX_DIV_FINE  = 2'h2;
  localparam logic [1:0] DLRC_IDX_HOLD_FINE = 2'h3;

  // ----------------------------------------------------------------------
  // Field positions and writable masks.
  // ----------------------------------------------------------------------
  localparam int unsigned DLRC_PHASE_LSB    = 5;
  localparam int unsigned DLRC_DIV_LSB      = 6;
  localparam int unsigned DLRC_FINE_LSB     = 2;
  localparam int unsigned DLRC_HOLD_BIT     = 7;
  localparam int unsigned DLRC_FINE_EN_BIT  = 5;
  localparam logic [7:0]  DLRC_MASK_PHASE   = 8'he0;
  localparam logic [7:0]  DLRC_MASK_DIVFINE = 8'hcc;
  localparam logic [7:0]  DLRC_MASK_HOLD    = 8'ha0;

  // ----------------------------------------------------------------------
  // Encodings.
  // ----------------------------------------------------------------------
  localparam logic [2:0] DLRC_PH_90  = 3'h0;
  localparam logic [2:0] DLRC_PH_0   = 3'h4;
  localparam logic [1:0] DLRC_FINE_0 = 2'h0;

  // ----------------------------------------------------------------------
  // Default settings standing in for the loaded bitstream image.
  // ----------------------------------------------------------------------
  localparam logic [7:0] DLRC_RST_PHASE   = 8'h80;
  localparam logic [7:0] DLRC_RST_DIVFINE = 8'h00;
  localparam logic [7:0] DLRC_RST_HOLD    = 8'h00;
  localparam logic [11:0] DLRC_RST_BASE   = 12'h000;

  typedef enum logic [1:0] {
    DLRC_ST_IDLE  = 2'b00,
    DLRC_ST_ARMED = 2'b01
  } dlrc_state_t;

endpackage : dlrc_pkg

//--- src/dlrc_top.sv
// Run-time configuration register set of a delay-locked loop target.
// Assumes the bus master drives address, write and read strobes in the fabric clock domain.
`timescale 1ns/10ps
module dlrc_top
  import dlrc_pkg::*;
#(
  parameter logic [11:0] BASE_ADDR = DLRC_RST_BASE
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        time_ref_mode_i,
  input  wire logic        loop_reset_n_i,
  input  wire logic        global_set_reset_net_i,
  input  wire logic [11:0] cfg_addr_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_wdata_i,
  output logic      [7:0]  cfg_rdata_o,
  output logic             cfg_rvalid_o,
  output logic      [2:0]  primary_phase_o,
  output logic      [1:0]  secondary_div_o,
  output logic      [1:0]  secondary_fine_o,
  output logic             hold_o,
  output logic             change_pending_o
);
  import dlrc_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  // Hit when the address lies in the four slots from the base up; its offset from the base picks the index.
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = ((a - BASE_ADDR) < 12'h004) && (a >= BASE_ADDR);
  endfunction : addr_hit

  logic [1:0]  idx;
  logic        wr_hit;
  logic        rd_hit;
  logic        apply_rst;
  logic [7:0]  phase_a_q;
  logic [7:0]  phase_b_q;
  logic [7:0]  divfine_q;
  logic [7:0]  hold_q;
  dlrc_state_t state_q;

  assign idx       = 2'(cfg_addr_i - BASE_ADDR);
  // Every target with this base takes the same write, so a broadcast needs no extra logic.
  assign wr_hit    = cfg_wr_i && addr_hit(cfg_addr_i) && time_ref_mode_i;
  assign rd_hit    = cfg_rd_i && addr_hit(cfg_addr_i);
  assign apply_rst = !loop_reset_n_i || global_set_reset_net_i;

  // ----------------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------------
  // Only documented fields are stored; reserved bits are masked off on write.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase_a_q <= DLRC_RST_PHASE;
      phase_b_q <= DLRC_RST_PHASE;
      divfine_q <= DLRC_RST_DIVFINE;
      hold_q    <= DLRC_RST_HOLD;
    end else if (wr_hit) begin
      case (idx)
        DLRC_IDX_PHASE_A:  phase_a_q <= cfg_wdata_i & DLRC_MASK_PHASE;
        DLRC_IDX_PHASE_B:  phase_b_q <= cfg_wdata_i & DLRC_MASK_PHASE;
        DLRC_IDX_DIV_FINE: divfine_q <= cfg_wdata_i & DLRC_MASK_DIVFINE;
        DLRC_IDX_HOLD_FINE: hold_q   <= cfg_wdata_i & DLRC_MASK_HOLD;
        default:           hold_q    <= hold_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------------
  // Registered read data, one cycle after the strobe; misses read zero.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o  <= 8'h00;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= rd_hit;
      if (rd_hit) begin
        case (idx)
          DLRC_IDX_PHASE_A:  cfg_rdata_o <= phase_a_q;
          DLRC_IDX_PHASE_B:  cfg_rdata_o <= phase_b_q;
          DLRC_IDX_DIV_FINE: cfg_rdata_o <= divfine_q;
          default:           cfg_rdata_o <= hold_q;
        endcase
      end else begin
        cfg_rdata_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pending change tracker.
  // ----------------------------------------------------------------------
  // A write arms the tracker; the loop's own reset or the global set/reset applies it. A write in the
  // same cycle as the reset stays armed, so a late change is never lost.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= DLRC_ST_IDLE;
    end else begin
      case (state_q)
        DLRC_ST_IDLE:  if (wr_hit) state_q <= DLRC_ST_ARMED;
        DLRC_ST_ARMED: if (apply_rst && !wr_hit) state_q <= DLRC_ST_IDLE;
        default:       state_q <= DLRC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Applied loop settings.
  // ----------------------------------------------------------------------
  // Settings reach the loop only on its reset or the global set/reset, so the output never jumps mid-lock.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      primary_phase_o  <= DLRC_RST_PHASE[DLRC_PHASE_LSB +: 3];
      secondary_div_o  <= DLRC_RST_DIVFINE[DLRC_DIV_LSB +: 2];
      secondary_fine_o <= DLRC_FINE_0;
      hold_o           <= 1'b0;
      change_pending_o <= 1'b0;
    end else begin
      // Follow the tracker's next state, so the flag drops at the same edge that applies the change.
      // Reading the current state alone would leave the flag high for one stale cycle after the apply.
      change_pending_o <= wr_hit || ((state_q == DLRC_ST_ARMED) && !apply_rst);
      if (apply_rst) begin
        primary_phase_o  <= phase_a_q[DLRC_PHASE_LSB +: 3];
        secondary_div_o  <= divfine_q[DLRC_DIV_LSB +: 2];
        secondary_fine_o <= hold_q[DLRC_FINE_EN_BIT] ?
                            divfine_q[DLRC_FINE_LSB +: 2] : DLRC_FINE_0;
        hold_o           <= hold_q[DLRC_HOLD_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence write_seq;
    wr_hit && idx == DLRC_IDX_HOLD_FINE;
  endsequence

  reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cfg_rvalid_o |-> (cfg_rdata_o & ~(DLRC_MASK_PHASE | DLRC_MASK_DIVFINE | DLRC_MASK_HOLD)) == 8'h00)
    else $error("Reserved bits read nonzero.");
  mode_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg_wr_i && !time_ref_mode_i) |=> $stable(divfine_q) && $stable(hold_q))
    else $error("Write accepted outside delay mode.");
  fine_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (apply_rst && !hold_q[DLRC_FINE_EN_BIT]) |=> secondary_fine_o == DLRC_FINE_0)
    else $error("Fine phase applied while disabled.");
  fine_pass_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (apply_rst && hold_q[DLRC_FINE_EN_BIT]) |=> secondary_fine_o == $past(divfine_q[3:2]))
    else $error("Fine phase not applied.");
  phase_apply_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    apply_rst |=> primary_phase_o == $past(phase_a_q[7:5]))
    else $error("Primary phase not applied on reset.");
  div_apply_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    apply_rst |=> secondary_div_o == $past(divfine_q[7:6]))
    else $error("Divider not applied on reset.");
  hold_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    write_seq |=> hold_q == ($past(cfg_wdata_i) & DLRC_MASK_HOLD))
    else $error("Write at offset not stored.");
  read_answer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_hit |=> cfg_rvalid_o ##1 !cfg_rvalid_o || $past(rd_hit, 1))
    else $error("Read not answered one cycle later.");
  pending_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_hit |=> change_pending_o)
    else $error("Write did not raise pending flag.");

  // ----------------------------------------------------------------------
  // Checks on storage, read back and the apply step, slot by slot.
  // ----------------------------------------------------------------------
  // Writable bits of one register slot; the checks below share this decode.
  function automatic logic [7:0] reg_mask(input logic [1:0] i);
    case (i)
      DLRC_IDX_DIV_FINE:  reg_mask = DLRC_MASK_DIVFINE;
      DLRC_IDX_HOLD_FINE: reg_mask = DLRC_MASK_HOLD;
      default:            reg_mask = DLRC_MASK_PHASE;
    endcase
  endfunction : reg_mask

  // A read that hits this target.
  sequence read_seq;
    rd_hit;
  endsequence

  // A reset pulse with no write racing it, which must clear the pending flag.
  sequence apply_seq;
    apply_rst && !wr_hit;
  endsequence

  // A write strobe that this target must not take.
  sequence refused_seq;
    cfg_wr_i && !wr_hit;
  endsequence

  // Read data must carry no reserved bit of the slot that was read.
  read_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    read_seq |=> (cfg_rdata_o & ~reg_mask($past(idx))) == 8'h00)
    else $error("Reserved bits of the read slot were nonzero.");

  // Each slot answers with its own stored value.
  read_first_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_hit && idx == DLRC_IDX_PHASE_A) |=> cfg_rdata_o == $past(phase_a_q))
    else $error("Read of the first phase slot returned a wrong value.");

  read_second_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_hit && idx == DLRC_IDX_PHASE_B) |=> cfg_rdata_o == $past(phase_b_q))
    else $error("Read of the second phase slot returned a wrong value.");

  read_divider_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_hit && idx == DLRC_IDX_DIV_FINE) |=> cfg_rdata_o == $past(divfine_q))
    else $error("Read of the divider slot returned a wrong value.");

  read_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_hit && idx == DLRC_IDX_HOLD_FINE) |=> cfg_rdata_o == $past(hold_q))
    else $error("Read of the hold slot returned a wrong value.");

  // Without a hit the read port stays quiet and shows zero.
  read_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !rd_hit |=> !cfg_rvalid_o && cfg_rdata_o == 8'h00)
    else $error("Read port active without a hit.");

  // A read outside the four slots is never answered.
  off_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg_rd_i && !addr_hit(cfg_addr_i)) |=> !cfg_rvalid_o)
    else $error("Read outside the target answered.");

  // Accepted writes land masked in the slot they address.
  write_first_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_hit && idx == DLRC_IDX_PHASE_A) |=> phase_a_q == ($past(cfg_wdata_i) & reg_mask(DLRC_IDX_PHASE_A)))
    else $error("Write to the first phase slot not stored.");

  write_second_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_hit && idx == DLRC_IDX_PHASE_B) |=> phase_b_q == ($past(cfg_wdata_i) & reg_mask(DLRC_IDX_PHASE_B)))
    else $error("Write to the second phase slot not stored.");

  write_divider_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_hit && idx == DLRC_IDX_DIV_FINE) |=> divfine_q == ($past(cfg_wdata_i) & reg_mask(DLRC_IDX_DIV_FINE)))
    else $error("Write to the divider slot not stored.");

  // A refused write, off range or outside delay mode, leaves every slot alone.
  refused_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    refused_seq |=> $stable(phase_a_q) && $stable(phase_b_q) && $stable(divfine_q) && $stable(hold_q))
    else $error("Refused write changed a register.");

  // The phase slots are guarded by the mode input just like the others.
  mode_phase_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg_wr_i && !time_ref_mode_i) |=> $stable(phase_a_q) && $stable(phase_b_q))
    else $error("Phase write accepted outside delay mode.");

  // An apply with no racing write clears the pending flag at once.
  pending_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    apply_seq |=> !change_pending_o)
    else $error("Pending flag survived the apply.");

  // A pending change is kept until an apply comes.
  pending_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (change_pending_o && !apply_rst) |=> change_pending_o)
    else $error("Pending flag dropped without an apply.");

  // The flag mirrors the tracker state after every edge.
  pending_state_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    change_pending_o == (state_q == DLRC_ST_ARMED))
    else $error("Pending flag disagrees with the tracker.");

  // The hold bit reaches the loop on an apply.
  hold_apply_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    apply_rst |=> hold_o == $past(hold_q[DLRC_HOLD_BIT]))
    else $error("Hold bit not applied on reset.");

  // Reset reloads the stand-in bitstream image; these checks run during reset on purpose.
  reset_regs_a: assert property (@(posedge core_clk_i)
    !rst_n_i |=> phase_a_q == DLRC_RST_PHASE && phase_b_q == DLRC_RST_PHASE &&
                 divfine_q == DLRC_RST_DIVFINE && hold_q == DLRC_RST_HOLD)
    else $error("Registers not loaded with their start values.");

  reset_outputs_a: assert property (@(posedge core_clk_i)
    !rst_n_i |=> !cfg_rvalid_o && cfg_rdata_o == 8'h00 && !change_pending_o && primary_phase_o == DLRC_PH_0)
    else $error("Outputs not at their start values after reset.");

endmodule : dlrc_top

//--- tb/dlrc_master.sv
// Bus master model standing in for system bus or fabric logic.
// Assumes one clock; requests launch 1 ns after a rising edge.
`timescale 1ns/10ps
module dlrc_master (
  input  wire logic        core_clk_i,
  input  wire logic        cfg_rvalid_i,
  input  wire logic [7:0]  cfg_rdata_i,
  output logic      [11:0] cfg_addr_o,
  output logic             cfg_wr_o,
  output logic             cfg_rd_o,
  output logic      [7:0]  cfg_wdata_o,
  output logic             loop_reset_n_o,
  output logic             gsr_o
);
  // Idle bus at time zero, so no strobe is seen before reset ends.
  initial begin
    {cfg_addr_o, cfg_wr_o, cfg_rd_o, cfg_wdata_o, gsr_o} = '0;
    loop_reset_n_o = 1'b1;
  end
  // One access held for exactly one sampling edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic v, output logic [7:0] q);
    @(posedge core_clk_i);
    #1;
    cfg_addr_o = a;
    cfg_wdata_o = d;
    cfg_wr_o = w;
    cfg_rd_o = !w;
    @(posedge core_clk_i);
    #1;
    v = cfg_rvalid_i;
    q = cfg_rdata_i;
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    // Released lines show the inverse, so a stale value can never pass.
    cfg_addr_o = ~a;
    cfg_wdata_o = ~d;
  endtask : xfer
  // Reset pulse after writes, so stored settings reach the loop.
  task automatic apply(input logic g);
    @(posedge core_clk_i);
    #1;
    gsr_o = g;
    loop_reset_n_o = g;
    @(posedge core_clk_i);
    #1;
    gsr_o = 1'b0;
    loop_reset_n_o = 1'b1;
  endtask : apply
endmodule : dlrc_master

//--- tb/dlrc_top_tb.sv
// Self-checking bench for the delay loop run-time registers.
// Assumes dlrc_master drives the bus; a shadow copy gives expectations.
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module dlrc_top_tb;
  import dlrc_pkg::*;
  localparam logic [11:0] BASE = 12'h0410;
  logic        core_clk_i = 0, rst_n_i = 0, mode = 1;
  logic        wr, rd, rv, lrn, global_set_reset_net, hold, pend, v;
  logic [11:0] addr, a;
  logic [7:0]  wd, rdat, q, d;
  logic [2:0]  ph;
  logic [1:0]  dv, fn;
  logic [7:0]  shadow [4];
  int          errors, cmp_count, cycles, seed, i;
  dlrc_top #(.BASE_ADDR(BASE)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .time_ref_mode_i(mode),
    .loop_reset_n_i(lrn), .global_set_reset_net_i(global_set_reset_net), .cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv), .primary_phase_o(ph), .secondary_div_o(dv),
    .secondary_fine_o(fn), .hold_o(hold), .change_pending_o(pend));
  dlrc_master i_mst (.core_clk_i(core_clk_i), .cfg_rvalid_i(rv), .cfg_rdata_i(rdat), .cfg_addr_o(addr),
    .cfg_wr_o(wr), .cfg_rd_o(rd), .cfg_wdata_o(wd), .loop_reset_n_o(lrn), .gsr_o(global_set_reset_net));
  // Clock and a hang guard well above the few hundred cycles needed.
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  // Writable bits of each register; everything else must stay zero.
  function automatic logic [7:0] wmask(input logic [1:0] r);
    return r == 2'h2 ? DLRC_MASK_DIVFINE : r == 2'h3 ? DLRC_MASK_HOLD : DLRC_MASK_PHASE;
  endfunction : wmask
  // Write one register; the shadow follows only when the write should land.
  task automatic put(input logic [11:0] ad, input logic [7:0] dd);
    i_mst.xfer(1'b1, ad, dd, v, q);
    if (mode && ad >= BASE && ad < BASE + 12'h004) begin
      shadow[ad[1:0]] = dd & wmask(ad[1:0]);
      `CHK("pending", 1'b1, pend)
    end
  endtask : put
  task automatic get(input logic [11:0] ad);
    logic hit;
    hit = ad >= BASE && ad < BASE + 12'h004;
    i_mst.xfer(1'b0, ad, 8'h00, v, q);
    `CHK("rvalid", hit, v)
    `CHK("rdata", hit ? shadow[ad[1:0]] : 8'h00, q)
  endtask : get
  // Pulse a reset and compare the applied settings with the shadow.
  task automatic apply_chk(input logic g);
    i_mst.apply(g);
    `CHK("phase", shadow[0][7:5], ph)
    `CHK("div", shadow[2][7:6], dv)
    `CHK("fine", shadow[3][5] ? shadow[2][3:2] : 2'h0, fn)
    `CHK("hold", shadow[3][7], hold)
    `CHK("pending", 1'b0, pend)
  endtask : apply_chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Reset values, all-ones data, three refused writes, map edges, then random traffic.
  initial begin
    seed = 32'hba44;
    shadow = '{8'h80, 8'h80, 8'h00, 8'h00};
    repeat (4) @(posedge core_clk_i);
    #1 rst_n_i = 1;
    `CHK("phase", DLRC_PH_0, ph)
    for (i = 0; i < 4; i++) get(BASE + 12'(i));
    for (i = 0; i < 4; i++) put(BASE + 12'(i), 8'hff);
    put(BASE - 12'h001, 8'h00);
    put(BASE + 12'h004, 8'h00);
    mode = 0;
    put(BASE + 12'h002, 8'h00);
    mode = 1;
    for (i = -1; i < 5; i++) get(BASE + 12'(i));
    apply_chk(1'b0);
    repeat (80) begin
      d = $random(seed);
      a = BASE + 12'({$random(seed)} % 6) - 12'h001;
      mode = ({$random(seed)} % 4) != 0;
      put(a, d);
      get(a);
      if (d[2:0] == 3'h0) apply_chk(d[3]);
    end
    apply_chk(1'b1);
    conclude();
  end
endmodule : dlrc_top_tb
